// ===== shared/gpq_pkg.sv
// Constants, types and register map of the GPIO input qualifier
package gpq_pkg;

    // Pin counts and grouping
    localparam int GPQ_PINS = 16;
    localparam int GPQ_GROUP = 8;
    localparam int GPQ_GROUPS = 2;
    localparam int GPQ_AIO_PINS = 6;
    localparam int GPQ_PERIPHS = 2;
    localparam int GPQ_PERIOD_W = 8;
    localparam int GPQ_COUNT_W = 9;

    // Qualification window lengths in samples
    localparam int GPQ_SAMPLES_SHORT = 3;
    localparam int GPQ_SAMPLES_LONG = 6;

    // Per-pin input selector codes
    typedef enum logic [1:0] {
        GPQ_SYNC = 2'h0,
        GPQ_QUAL3 = 2'h1,
        GPQ_QUAL6 = 2'h2,
        GPQ_RAW = 2'h3
    } gpq_mode_e;

    // Register byte offsets
    localparam logic [7:0] GPQ_OFS_QUAL_SELECT = 8'h00;
    localparam logic [7:0] GPQ_OFS_QUAL_PERIOD = 8'h04;
    localparam logic [7:0] GPQ_OFS_PORT_DATA = 8'h08;
    localparam logic [7:0] GPQ_OFS_PORT_DIR = 8'h0C;
    localparam logic [7:0] GPQ_OFS_ANALOG_PIN_SELECT = 8'h10;
    localparam logic [7:0] GPQ_OFS_ANALOG_DATA = 8'h14;
    localparam logic [7:0] GPQ_OFS_ANALOG_DIR = 8'h18;
    localparam logic [7:0] GPQ_OFS_PERIPH_ROUTE = 8'h1C;

    // Values after reset
    localparam logic [31:0] GPQ_RST_QUAL_SELECT = 32'h0000_0000;
    localparam logic [15:0] GPQ_RST_QUAL_PERIOD = 16'h0000;
    localparam logic [15:0] GPQ_RST_PORT = 16'h0000;
    localparam logic [31:0] GPQ_RST_ANALOG_SEL = 32'hAAAA_AAAA;
    localparam logic [5:0] GPQ_RST_AIO = 6'h00;
    localparam logic [31:0] GPQ_RST_ROUTE = 32'h0000_0000;
    // Idle level of each peripheral input: input 0 idles low, 1 high
    localparam logic [1:0] GPQ_PERIPH_DEFAULT = 2'h2;

    // Upper-bit positions of the analog select fields that own a pin
    localparam int GPQ_AIO_UPPER_BIT [0:5] = '{5, 9, 13, 21, 25, 29};

    // Register request from the software port
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gpq_req_s;

endpackage

// ===== logic/gpq_pin.sv
// Per-pin synchronizer and sampling-window qualifier
`timescale 1ns/1ps
module gpq_pin
    import gpq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_async,
    input wire logic sample_en,
    input wire gpq_mode_e mode,
    output logic level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic sync_reg;
    logic [5:0] hist_reg;
    logic qual_reg;
    logic out_reg;
    logic short_same;
    logic long_same;

    // Three-stage chain; only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level counts only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_reg <= 1'b0;
        else if (s2_reg == s3_reg)
            sync_reg <= s3_reg;
    end

    // Sample history, shifted at the group sampling rate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hist_reg <= 6'h00;
        else if (sample_en)
            hist_reg <= {hist_reg[4:0], sync_reg};
    end

    // Window spans n samples, so n-1 sampling periods
    assign short_same = (&hist_reg[2:0]) | ~(|hist_reg[2:0]);
    assign long_same = (&hist_reg) | ~(|hist_reg);

    // Qualified level moves only on a unanimous window
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            qual_reg <= 1'b0;
        else if (mode == GPQ_QUAL3 && short_same)
            qual_reg <= hist_reg[0];
        else if (mode == GPQ_QUAL6 && long_same)
            qual_reg <= hist_reg[0];
    end

    // Output selection; the bypass path captures the pin in one flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            out_reg <= 1'b0;
        else
        begin
            case (mode)
                GPQ_SYNC: out_reg <= sync_reg;
                GPQ_QUAL3: out_reg <= qual_reg;
                GPQ_QUAL6: out_reg <= qual_reg;
                GPQ_RAW: out_reg <= pin_async;
                default: out_reg <= sync_reg;
            endcase
        end
    end

    assign level = out_reg;

endmodule

// ===== logic/gpq_top.sv
// GPIO input qualifier with analog pin select and register port
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module gpq_top
    import gpq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire gpq_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire logic [15:0] gpio_in,
    output logic [15:0] gpio_out,
    output logic [15:0] gpio_oe,
    output logic [15:0] pin_level,
    output logic [1:0] periph_in,
    input wire logic [5:0] aio_in,
    output logic [5:0] aio_out,
    output logic [5:0] aio_oe
);

    logic [31:0] qual_select_reg;
    logic [15:0] qual_period_reg;
    logic [15:0] port_data_reg;
    logic [15:0] port_dir_reg;
    logic [31:0] analog_pin_select_reg;
    logic [5:0] analog_data_reg;
    logic [5:0] analog_dir_reg;
    logic [31:0] periph_route_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] periph_reg;
    logic [5:0] aio_oe_reg;
    logic [5:0] aio_digital;
    logic [5:0] aio_level;
    logic [15:0] level;
    logic [GPQ_GROUPS-1:0] sample_en;
    logic wr_hit_sel;
    logic wr_hit_per;
    logic wr_hit_data;
    logic wr_hit_dir;
    logic wr_hit_asel;
    logic wr_hit_adata;
    logic wr_hit_adir;
    logic wr_hit_route;

    // Write decode; unmapped writes are dropped silently.
    // Decode is exact on all eight address bits, so aliases of a
    // register offset never reach it.
    assign wr_hit_sel = reg_req.wr && reg_req.addr == GPQ_OFS_QUAL_SELECT;
    assign wr_hit_per = reg_req.wr && reg_req.addr == GPQ_OFS_QUAL_PERIOD;
    assign wr_hit_data = reg_req.wr && reg_req.addr == GPQ_OFS_PORT_DATA;
    assign wr_hit_dir = reg_req.wr && reg_req.addr == GPQ_OFS_PORT_DIR;
    assign wr_hit_asel = reg_req.wr
        && reg_req.addr == GPQ_OFS_ANALOG_PIN_SELECT;
    assign wr_hit_adata = reg_req.wr && reg_req.addr == GPQ_OFS_ANALOG_DATA;
    assign wr_hit_adir = reg_req.wr && reg_req.addr == GPQ_OFS_ANALOG_DIR;
    assign wr_hit_route = reg_req.wr
        && reg_req.addr == GPQ_OFS_PERIPH_ROUTE;

    // Selector register, two bits per pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            qual_select_reg <= GPQ_RST_QUAL_SELECT;
        else if (wr_hit_sel)
            qual_select_reg <= reg_req.wdata;
    end

    // Sampling periods, one byte per group of eight pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            qual_period_reg <= GPQ_RST_QUAL_PERIOD;
        else if (wr_hit_per)
            qual_period_reg <= reg_req.wdata[15:0];
    end

    // Output latch; reads of this offset see the pins instead
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            port_data_reg <= GPQ_RST_PORT;
        else if (wr_hit_data)
            port_data_reg <= reg_req.wdata[15:0];
    end

    // Direction, one bit per pin, high drives the pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            port_dir_reg <= GPQ_RST_PORT;
        else if (wr_hit_dir)
            port_dir_reg <= reg_req.wdata[15:0];
    end

    // Analog pin select; all fields leave digital unassigned at reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            analog_pin_select_reg <= GPQ_RST_ANALOG_SEL;
        else if (wr_hit_asel)
            analog_pin_select_reg <= reg_req.wdata;
    end

    // Analog pin output latch and direction
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            analog_data_reg <= GPQ_RST_AIO;
        else if (wr_hit_adata)
            analog_data_reg <= reg_req.wdata[5:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            analog_dir_reg <= GPQ_RST_AIO;
        else if (wr_hit_adir)
            analog_dir_reg <= reg_req.wdata[5:0];
    end

    // Peripheral routing: low half feeds input 0, high half input 1
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            periph_route_reg <= GPQ_RST_ROUTE;
        else if (wr_hit_route)
            periph_route_reg <= reg_req.wdata;
    end

    // Sample-enable divider per group; one pulse every 2n cycles.
    // Counter is one bit wider than the period field so that 2n-1
    // fits for the largest period.
    // Free running: the first sample after a pin change may come
    // anywhere within one sampling period.
    genvar g;
    generate
        for (g = 0; g < GPQ_GROUPS; g++)
        begin : grp
            logic [GPQ_COUNT_W-1:0] cnt_reg;
            logic [GPQ_PERIOD_W-1:0] per;
            logic [GPQ_COUNT_W-1:0] limit;
            assign per = qual_period_reg[g*GPQ_PERIOD_W +: GPQ_PERIOD_W];
            assign limit = {per, 1'b0} - 9'h001;
            // Period zero means every cycle is a sample
            assign sample_en[g] = (per == 8'h00) || (cnt_reg == limit);

            // Overshoot after a period change restarts without a pulse
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_reg <= 9'h000;
                else if (per == 8'h00 || cnt_reg >= limit)
                    cnt_reg <= 9'h000;
                else
                    cnt_reg <= cnt_reg + 9'h001;
            end
        end
    endgenerate

    // One conditioning channel per pin, group picks its sample rate
    genvar p;
    generate
        for (p = 0; p < GPQ_PINS; p++)
        begin : pin
            gpq_pin u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .pin_async(gpio_in[p]),
                .sample_en(sample_en[p / GPQ_GROUP]),
                .mode(gpq_mode_e'(qual_select_reg[2*p +: 2])),
                .level(level[p])
            );
        end
    endgenerate

    // Analog pins used as digital inputs get the plain synchronizer
    genvar a;
    generate
        for (a = 0; a < GPQ_AIO_PINS; a++)
        begin : aio
            gpq_pin u_aio (
                .clk(clk),
                .rst_n(rst_n),
                .pin_async(aio_in[a]),
                .sample_en(1'b1),
                .mode(GPQ_SYNC),
                .level(aio_level[a])
            );
            // Upper field bit low hands the pin to digital I/O
            assign aio_digital[a] =
                ~analog_pin_select_reg[GPQ_AIO_UPPER_BIT[a]];
        end
    endgenerate

    // Analog pin drive; an unassigned field keeps the driver off.
    // Registered so the enable never glitches while fields change.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            aio_oe_reg <= GPQ_RST_AIO;
        else
            aio_oe_reg <= analog_dir_reg & aio_digital;
    end

    // Peripheral inputs: several routed pins combine toward the
    // non-idle level, so any one pin can pull the input active
    genvar q;
    generate
        for (q = 0; q < GPQ_PERIPHS; q++)
        begin : per_in
            logic [15:0] mask;
            logic routed;
            logic merged;
            assign mask = periph_route_reg[16*q +: 16];
            assign routed = |mask;
            assign merged = GPQ_PERIPH_DEFAULT[q]
                ? &(level | ~mask)
                : |(level & mask);

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    periph_reg[q] <= GPQ_PERIPH_DEFAULT[q];
                else if (routed)
                    periph_reg[q] <= merged;
                else
                    periph_reg[q] <= GPQ_PERIPH_DEFAULT[q];
            end
        end
    endgenerate

    // Read mux; unmapped offsets and idle cycles answer zero.
    // Port data reads return conditioned levels, not the latch.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                GPQ_OFS_QUAL_SELECT: rdata_next = qual_select_reg;
                GPQ_OFS_QUAL_PERIOD: rdata_next = {16'h0000, qual_period_reg};
                GPQ_OFS_PORT_DATA: rdata_next = {16'h0000, level};
                GPQ_OFS_PORT_DIR: rdata_next = {16'h0000, port_dir_reg};
                GPQ_OFS_ANALOG_PIN_SELECT: rdata_next = analog_pin_select_reg;
                GPQ_OFS_ANALOG_DATA: rdata_next = {26'h0, aio_level};
                GPQ_OFS_ANALOG_DIR: rdata_next = {26'h0, analog_dir_reg};
                GPQ_OFS_PERIPH_ROUTE: rdata_next = periph_route_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rdata_next;
    end

    // All outputs come straight from flops
    assign reg_rdata = rdata_reg;
    assign gpio_out = port_data_reg;
    assign gpio_oe = port_dir_reg;
    assign pin_level = level;
    assign periph_in = periph_reg;
    assign aio_out = analog_data_reg;
    assign aio_oe = aio_oe_reg;

endmodule

// ===== bench/gpq_sva.sv
// Checker for the GPIO input qualifier ports, bound to its top module
`timescale 1ns/1ps
module gpq_sva
    import gpq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire gpq_req_s reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] gpio_in,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe,
    input wire logic [15:0] pin_level,
    input wire logic [1:0] periph_in,
    input wire logic [5:0] aio_in,
    input wire logic [5:0] aio_out,
    input wire logic [5:0] aio_oe
);
    logic [31:0] sel_reg;
    logic [31:0] route_reg;
    logic [31:0] asel_reg;
    logic [5:0] adir_reg;
    logic [5:0] aio_want;
    logic last_reg;
    logic [2:0] run_reg;
    logic port_wr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    assign port_wr = reg_req.wr && reg_req.addr == GPQ_OFS_PORT_DATA;

    // Shadow of the configuration, only software writes move it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= GPQ_RST_QUAL_SELECT;
            route_reg <= GPQ_RST_ROUTE;
            asel_reg <= GPQ_RST_ANALOG_SEL;
            adir_reg <= GPQ_RST_AIO;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == GPQ_OFS_QUAL_SELECT) sel_reg <= reg_req.wdata;
            if (reg_req.addr == GPQ_OFS_PERIPH_ROUTE) route_reg <= reg_req.wdata;
            if (reg_req.addr == GPQ_OFS_ANALOG_PIN_SELECT) asel_reg <= reg_req.wdata;
            if (reg_req.addr == GPQ_OFS_ANALOG_DIR) adir_reg <= reg_req.wdata[5:0];
        end
    end

    // Held cycles of pin 0 in sync-only mode; a mode change restarts it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_reg <= 1'b0;
            run_reg <= 3'h0;
        end
        else
        begin
            last_reg <= gpio_in[0];
            if (gpio_in[0] != last_reg || sel_reg[1:0] != 2'h0) run_reg <= 3'h0;
            else if (run_reg != 3'h7) run_reg <= run_reg + 3'h1;
        end
    end

    // Drive enable wanted per analog pin
    always_comb
    begin
        for (int i = 0; i < GPQ_AIO_PINS; i++)
            aio_want[i] = adir_reg[i] & ~asel_reg[GPQ_AIO_UPPER_BIT[i]];
    end

    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    port_read_a: assert property (
        $past(reg_req.rd && reg_req.addr == GPQ_OFS_PORT_DATA)
        |-> reg_rdata == {16'h0000, $past(pin_level)})
        else $error("port data read is not the pin level");
    latch_load_a: assert property (
        port_wr |=> gpio_out == $past(reg_req.wdata[15:0]))
        else $error("output latch not loaded by write");
    latch_hold_a: assert property (!port_wr |=> $stable(gpio_out))
        else $error("output latch moved without write");
    raw_path_a: assert property (
        sel_reg == 32'hFFFF_FFFF |=> pin_level == $past(gpio_in))
        else $error("raw mode does not pass pin level");
    sync_follow_a: assert property (run_reg >= 3'h4 |-> pin_level[0] == last_reg)
        else $error("sync mode level not followed");
    sync_stages_a: assert property (
        $rose(gpio_in[0]) && sel_reg[1:0] == 2'h0 && !pin_level[0]
        |=> !pin_level[0] [*2])
        else $error("sync mode faster than two stages");
    route_idle_a: assert property (
        route_reg == 32'h0 |=> periph_in == GPQ_PERIPH_DEFAULT)
        else $error("unrouted peripheral input not at default");
    route_or_a: assert property (route_reg[15:0] != 16'h0
        |=> periph_in[0] == $past(|(pin_level & route_reg[15:0])))
        else $error("peripheral input 0 not OR of routed pins");
    route_and_a: assert property (route_reg[31:16] != 16'h0
        |=> periph_in[1] == $past(&(pin_level | ~route_reg[31:16])))
        else $error("peripheral input 1 not AND of routed pins");
    aio_enable_a: assert property (1'b1 |=> aio_oe == $past(aio_want))
        else $error("analog pin enable wrong");

    cover property (sel_reg == 32'hFFFF_FFFF && gpio_in != 16'h0);
    cover property (route_reg[15:0] != 16'h0 && periph_in[0]);
    cover property ($past(reg_req.rd && reg_req.addr == GPQ_OFS_PORT_DATA));
endmodule

bind gpq_top gpq_sva chk
(
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_level(pin_level), .periph_in(periph_in), .aio_in(aio_in),
    .aio_out(aio_out), .aio_oe(aio_oe)
);

// ===== bench/gpq_src.sv
// Model of the external signals that drive the pins
`timescale 1ns/1ps
module gpq_src
(
    input wire logic clk,
    output logic [15:0] gpio_in,
    output logic [5:0] aio_in
);
    // Quiet pins at time zero
    initial
    begin
        gpio_in = 16'h0000;
        aio_in = 6'h00;
    end

    // New levels launched just after an edge, never on it
    task automatic drive(input logic [15:0] p, input logic [5:0] a);
        @(posedge clk);
        gpio_in <= p;
        aio_in <= a;
    endtask

    // Keeps levels; qualified modes need several sampling periods
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
endmodule

// ===== bench/testbench.sv
// Self-checking testbench of the GPIO input qualifier
`timescale 1ns/1ps
module testbench
    import gpq_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    gpq_req_s reg_req = '0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic [15:0] gpio_in, gpio_out, gpio_oe, pin_level;
    logic [1:0] periph_in;
    logic [5:0] aio_in, aio_out, aio_oe;
    int fails = 0;
    int checks_done = 0;

    gpq_top dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pin_level(pin_level), .periph_in(periph_in),
        .aio_in(aio_in), .aio_out(aio_out), .aio_oe(aio_oe));
    gpq_src src (.clk(clk), .gpio_in(gpio_in), .aio_in(aio_in));

    // 10 MHz system clock
    always #50 clk = ~clk;

    task automatic close_out();
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask

    // Lets registered outputs catch up with a write
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk_reg(GPQ_OFS_QUAL_SELECT, 32'h0);
        chk_reg(GPQ_OFS_QUAL_PERIOD, 32'h0);
        chk_reg(GPQ_OFS_ANALOG_PIN_SELECT, 32'hAAAA_AAAA);
        wr_reg(8'h24, 32'hFFFF_FFFF);
        chk_reg(8'h24, 32'h0);
        chk_reg(GPQ_OFS_QUAL_SELECT, 32'h0);
        check({30'h0, periph_in}, {30'h0, GPQ_PERIPH_DEFAULT});
        check({26'h0, aio_oe}, 32'h0);
    endtask

    task automatic t_sync();
        int n = 0;
        src.drive(16'h0001, 6'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({31'h0, pin_level[0]}, 32'h0);
        while (pin_level[0] !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        check({31'h0, pin_level[0]}, 32'h1);
        src.drive(16'h0000, 6'h00);
        src.hold(8);
    endtask

    // Pin 0 three samples and pin 1 six at period 2; pin 8 six at period 0
    task automatic t_qual();
        int f0 = 0;
        int f1 = 0;
        int f8 = 0;
        wr_reg(GPQ_OFS_QUAL_PERIOD, 32'h0000_0002);
        wr_reg(GPQ_OFS_QUAL_SELECT, 32'h0002_0009);
        chk_reg(GPQ_OFS_QUAL_PERIOD, 32'h0000_0002);
        src.drive(16'h0103, 6'h00);
        src.drive(16'h0000, 6'h00);
        src.hold(40);
        check({16'h0, pin_level & 16'h0103}, 32'h0);
        src.drive(16'h0103, 6'h00);
        for (int n = 1; n <= 40; n++)
        begin
            @(negedge clk);
            if (f0 == 0 && pin_level[0] === 1'b1) f0 = n;
            if (f1 == 0 && pin_level[1] === 1'b1) f1 = n;
            if (f8 == 0 && pin_level[8] === 1'b1) f8 = n;
        end
        check({31'h0, f0 >= 9 && f0 <= 22}, 32'h1);
        check({31'h0, f1 >= 21 && f1 <= 34}, 32'h1);
        check({31'h0, f8 >= 6 && f8 <= 16}, 32'h1);
        src.drive(16'h0000, 6'h00);
        src.hold(40);
    endtask

    task automatic t_raw_port();
        wr_reg(GPQ_OFS_QUAL_SELECT, 32'hFFFF_FFFF);
        src.drive(16'h5A3D, 6'h00);
        src.drive(16'h5A3C, 6'h00);
        @(negedge clk);
        check({16'h0, pin_level}, 32'h0000_5A3D);
        wr_reg(GPQ_OFS_PORT_DIR, 32'h0000_FFFF);
        wr_reg(GPQ_OFS_PORT_DATA, 32'h0000_C3A5);
        @(negedge clk);
        check({gpio_oe, gpio_out}, 32'hFFFF_C3A5);
        chk_reg(GPQ_OFS_PORT_DATA, 32'h0000_5A3C);
    endtask

    // Pins read 0,0,1,1 on 0..3 while raw mode holds
    task automatic t_route();
        wr_reg(GPQ_OFS_PERIPH_ROUTE, 32'h0006_0005);
        settle();
        check({30'h0, periph_in}, 32'h1);
        wr_reg(GPQ_OFS_PERIPH_ROUTE, 32'h000C_000C);
        settle();
        check({30'h0, periph_in}, 32'h3);
        wr_reg(GPQ_OFS_PERIPH_ROUTE, 32'h0);
        settle();
        check({30'h0, periph_in}, {30'h0, GPQ_PERIPH_DEFAULT});
    endtask

    task automatic t_analog();
        wr_reg(GPQ_OFS_ANALOG_DIR, 32'h3F);
        wr_reg(GPQ_OFS_ANALOG_PIN_SELECT, 32'h0);
        settle();
        check({26'h0, aio_oe}, 32'h3F);
        wr_reg(GPQ_OFS_ANALOG_PIN_SELECT, 32'h5555_5555);
        settle();
        check({26'h0, aio_oe}, 32'h3F);
        wr_reg(GPQ_OFS_ANALOG_PIN_SELECT, 32'h0000_0200);
        settle();
        check({26'h0, aio_oe}, 32'h3D);
        wr_reg(GPQ_OFS_ANALOG_DATA, 32'h2A);
        src.drive(16'h5A3C, 6'h15);
        src.hold(6);
        @(negedge clk);
        check({26'h0, aio_out}, 32'h2A);
        chk_reg(GPQ_OFS_ANALOG_DATA, 32'h15);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_sync();
        t_qual();
        t_raw_port();
        t_route();
        t_analog();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
